// file: pkg/cpwm_defines.svh
// register offsets, field positions, reset values and timing constants
`ifndef CPWM_DEFINES_SVH
`define CPWM_DEFINES_SVH
// register byte offsets
`define CPWM_OFF_CTRL     8'h00
`define CPWM_OFF_MODE     8'h04
`define CPWM_OFF_OE       8'h08
`define CPWM_OFF_OCTL     8'h0C
`define CPWM_OFF_START    8'h10
`define CPWM_OFF_PER_BUF  8'h14
`define CPWM_OFF_HALF_BUF 8'h18
`define CPWM_OFF_DEAD     8'h1C
`define CPWM_OFF_DUTY_U   8'h20
`define CPWM_OFF_DUTY_V   8'h24
`define CPWM_OFF_DUTY_W   8'h28
`define CPWM_OFF_CNT3     8'h2C
`define CPWM_OFF_CNT4     8'h30
`define CPWM_OFF_STATUS   8'h34
`define CPWM_OFF_PER      8'h38
`define CPWM_OFF_HALF     8'h3C
// field positions
`define CPWM_CTRL_CLK     1:0
`define CPWM_CTRL_CLR     5:4
`define CPWM_MODE_FLD     3:0
`define CPWM_OE_FLD       5:0
`define CPWM_OCTL_FLD     7:0
`define CPWM_OCTL_TOG     6
`define CPWM_OCTL_LVL     0
`define CPWM_START_RUN    0
// field codes
`define CPWM_CLR_PEAK     2'h1
`define CPWM_MODE_PEAK    4'hD
`define CPWM_MODE_TROUGH  4'hE
`define CPWM_MODE_BOTH    4'hF
`define CPWM_DIV_1        6'h00
`define CPWM_DIV_4        6'h03
`define CPWM_DIV_16       6'h0F
`define CPWM_DIV_64       6'h3F
// reset values
`define CPWM_RST_CTRL     8'h00
`define CPWM_RST_MODE     4'h0
`define CPWM_RST_OE       6'h00
`define CPWM_RST_OCTL     8'h00
// timing: clock period and programmable pulse period range
`define CPWM_CLK_NS       50
`define CPWM_MIN_PER_NS   100
`define CPWM_MAX_PER_NS   3270000
`define CPWM_MIN_PER_CYC  ((`CPWM_MIN_PER_NS+`CPWM_CLK_NS-1)/`CPWM_CLK_NS)
`define CPWM_MAX_PER_CYC  (`CPWM_MAX_PER_NS/`CPWM_CLK_NS)
`endif

// file: pkg/cpwm_pkg.sv
// types shared by the complementary pwm block
package cpwm_pkg;
    // dead time generator state of one phase
    typedef enum logic [1:0] {ST_NEG, ST_DEAD, ST_POS} cpwm_dt_state_type;
endpackage

// file: hw/cpwm_prescale.sv
// counter clock prescaler producing a one-cycle count tick
`timescale 1ns/1ns
`include "cpwm_defines.svh"
module cpwm_prescale
(
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    input  wire logic       run,
    input  wire logic [1:0] sel,
    output logic            tick
);
    logic [5:0] div_reg;
    logic [5:0] limit;

    // divide by 1, 4, 16 or 64
    always_comb
    begin
        unique case (sel)
            2'h0: limit = `CPWM_DIV_1;
            2'h1: limit = `CPWM_DIV_4;
            2'h2: limit = `CPWM_DIV_16;
            2'h3: limit = `CPWM_DIV_64;
        endcase
    end

    assign tick = run && (div_reg >= limit);

    // divider count, restarts while stopped
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n || !run || tick)
            div_reg <= '0;
        else
            div_reg <= div_reg + 6'h01;
    end
endmodule // cpwm_prescale

// file: hw/cpwm_phase.sv
// one phase: non-overlapping positive and negative drive with dead time
`timescale 1ns/1ns
module cpwm_phase
#(
    parameter int W = 16
)
(
    input  wire logic         clk_sys,
    input  wire logic         rst_n,
    input  wire logic         tick,
    input  wire logic         en,
    input  wire logic         raw,
    input  wire logic [W-1:0] dead,
    output logic              pos_act,
    output logic              neg_act
);
    cpwm_pkg::cpwm_dt_state_type state_reg;
    logic [W-1:0]                cnt_reg;

    // both sides pass through the dead state before turning on
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n || !en)
        begin
            state_reg <= cpwm_pkg::ST_DEAD;
            cnt_reg   <= dead;
        end
        else if (tick)
        begin
            unique case (state_reg)
                cpwm_pkg::ST_POS:
                    if (!raw)
                    begin
                        state_reg <= cpwm_pkg::ST_DEAD;
                        cnt_reg   <= dead;
                    end
                cpwm_pkg::ST_NEG:
                    if (raw)
                    begin
                        state_reg <= cpwm_pkg::ST_DEAD;
                        cnt_reg   <= dead;
                    end
                cpwm_pkg::ST_DEAD:
                    if (cnt_reg == '0)
                        state_reg <= raw ? cpwm_pkg::ST_POS
                                         : cpwm_pkg::ST_NEG;
                    else
                        cnt_reg <= cnt_reg - 1'b1;
            endcase
        end
    end

    assign pos_act = (state_reg == cpwm_pkg::ST_POS);
    assign neg_act = (state_reg == cpwm_pkg::ST_NEG);

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    chk_no_overlap: assert property (
        !(pos_act && neg_act))
        else $error("both sides of a phase active");
    chk_pos_after_dead: assert property (
        $rose(pos_act) |-> $past(state_reg) == cpwm_pkg::ST_DEAD)
        else $error("positive side turned on without dead time");
    cov_dead_to_pos: cover property (
        state_reg == cpwm_pkg::ST_DEAD ##1 pos_act);
endmodule // cpwm_phase

// file: hw/cpwm_top.sv
// three-phase complementary pwm timer with avalon-mm register slave
//
// Our own choices: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ns
`include "cpwm_defines.svh"
// What this block does
// - three phases, each positive and negative output, never both active
// - duty follows each duty register, 0% to 100% reachable
// - toggle output changes state in step with the carrier period
// - counters wide enough for 100 ns to 3.27 ms at 20 MHz
// - duty and period buffers copied to compare registers on match
// - software may write buffer registers at any time
// - writing phase w duty buffer moves buffers to temporaries
// - peak mode blocks the move near peak, trough mode near trough
// - temporaries copied to compare at boundary end, timing by mode field
// - in boundary interval outputs follow temporary and compare values
// - before the turn, old data and its matches take precedence
// - after the turn, new data and its matches take precedence
// - an output turns active only after its partner returned
// - mode register puts both channels into complementary operation
// - period register holds half period plus dead time, with buffer
// - half-cycle register reloads from its buffer like duty registers
// - output enable register gates each complementary pin
// - output control register enables the toggle output
// - control register picks counter clear source and count clock
module cpwm_top
#(
    parameter int MAX_PER_CYC = `CPWM_MAX_PER_CYC,
    parameter int CNT_W       = $clog2(MAX_PER_CYC + 1)
)
(
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    output logic             period_toggle_pin,
    output logic             phase_u_positive_pin,
    output logic             phase_u_output_pin_alt,
    output logic             phase_u_negative_pin,
    output logic             phase_v_positive_pin,
    output logic             phase_v_negative_pin,
    output logic             phase_w_positive_pin,
    output logic             phase_w_negative_pin
);
    logic [7:0]       ctrl_reg;
    logic [3:0]       mode_reg;
    logic [5:0]       oe_reg;
    logic [7:0]       octl_reg;
    logic             run_reg;
    logic [CNT_W-1:0] per_buf_reg;
    logic [CNT_W-1:0] half_buf_reg;
    logic [CNT_W-1:0] dead_reg;
    logic [CNT_W-1:0] duty_buf_reg [0:2];
    logic [CNT_W-1:0] tmp_per_reg;
    logic [CNT_W-1:0] tmp_half_reg;
    logic [CNT_W-1:0] tmp_duty_reg [0:2];
    logic [CNT_W-1:0] per_reg;
    logic [CNT_W-1:0] half_reg;
    logic [CNT_W-1:0] cmp_reg [0:2];
    logic [CNT_W-1:0] cnt3_reg;
    logic [CNT_W-1:0] cnt4_reg;
    logic             dir_up_reg;
    logic             pend_reg;
    logic             tb1_q_reg;
    logic             tb2_q_reg;
    logic             turn_reg;
    logic             tog_reg;
    logic [5:0]       pin_reg;
    logic             wait_reg;
    logic [31:0]      rdata_reg;
    logic             comp;
    logic             tick;
    logic             peak_ev;
    logic             trough_ev;
    logic             in_tb1;
    logic             in_tb2;
    logic             peak_sel;
    logic             trough_sel;
    logic             move;
    logic             xfer;
    logic             wr_acc;
    logic [CNT_W-1:0] wd;
    logic [2:0]       pos_act;
    logic [2:0]       neg_act;
    logic [2:0]       raw;

    // write strobe for one register offset
    function automatic logic hit(input logic [7:0] off);
        return wr_acc && (avs_address == off);
    endfunction

    // one count step up or down
    function automatic logic [CNT_W-1:0] step(input logic [CNT_W-1:0] v,
                                              input logic up);
        return up ? v + 1'b1 : v - 1'b1;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // avalon-mm slave: one wait cycle, then the answer
    assign wr_acc = avs_write && !wait_reg;
    assign wd     = avs_writedata[CNT_W-1:0];

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            wait_reg <= 1'b1;
        else if ((avs_read || avs_write) && wait_reg)
            wait_reg <= 1'b0;
        else
            wait_reg <= 1'b1;
    end

    // read data is latched in the cycle that drops waitrequest
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            rdata_reg <= '0;
        else if (avs_read && wait_reg)
        begin
            unique case (avs_address)
                `CPWM_OFF_CTRL:     rdata_reg <= 32'(ctrl_reg);
                `CPWM_OFF_MODE:     rdata_reg <= 32'(mode_reg);
                `CPWM_OFF_OE:       rdata_reg <= 32'(oe_reg);
                `CPWM_OFF_OCTL:     rdata_reg <= 32'(octl_reg);
                `CPWM_OFF_START:    rdata_reg <= 32'(run_reg);
                `CPWM_OFF_PER_BUF:  rdata_reg <= 32'(per_buf_reg);
                `CPWM_OFF_HALF_BUF: rdata_reg <= 32'(half_buf_reg);
                `CPWM_OFF_DEAD:     rdata_reg <= 32'(dead_reg);
                `CPWM_OFF_DUTY_U:   rdata_reg <= 32'(duty_buf_reg[0]);
                `CPWM_OFF_DUTY_V:   rdata_reg <= 32'(duty_buf_reg[1]);
                `CPWM_OFF_DUTY_W:   rdata_reg <= 32'(duty_buf_reg[2]);
                `CPWM_OFF_CNT3:     rdata_reg <= 32'(cnt3_reg);
                `CPWM_OFF_CNT4:     rdata_reg <= 32'(cnt4_reg);
                `CPWM_OFF_STATUS:   rdata_reg <= 32'({pin_reg, tog_reg,
                                        pend_reg, in_tb2, in_tb1,
                                        dir_up_reg});
                `CPWM_OFF_PER:      rdata_reg <= 32'(per_reg);
                `CPWM_OFF_HALF:     rdata_reg <= 32'(half_reg);
                default:            rdata_reg <= '0;
            endcase
        end
    end

    assign avs_readdata    = rdata_reg;
    assign avs_waitrequest = wait_reg;

    ////////////////////////////////////////////////////////////////////
    // control, mode and output registers
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            ctrl_reg <= `CPWM_RST_CTRL;
            mode_reg <= `CPWM_RST_MODE;
            oe_reg   <= `CPWM_RST_OE;
            octl_reg <= `CPWM_RST_OCTL;
            run_reg  <= 1'b0;
            dead_reg <= '0;
        end
        else
        begin
            if (hit(`CPWM_OFF_CTRL))
                ctrl_reg <= avs_writedata[7:0];
            if (hit(`CPWM_OFF_MODE))
                mode_reg <= avs_writedata[`CPWM_MODE_FLD];
            if (hit(`CPWM_OFF_OE))
                oe_reg <= avs_writedata[`CPWM_OE_FLD];
            if (hit(`CPWM_OFF_OCTL))
                octl_reg <= avs_writedata[`CPWM_OCTL_FLD];
            if (hit(`CPWM_OFF_START))
                run_reg <= avs_writedata[`CPWM_START_RUN];
            if (hit(`CPWM_OFF_DEAD))
                dead_reg <= wd;
        end
    end

    // buffer registers accept writes in any counter phase
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            per_buf_reg  <= '0;
            half_buf_reg <= '0;
            for (int i = 0; i < 3; i++)
                duty_buf_reg[i] <= '0;
        end
        else
        begin
            if (hit(`CPWM_OFF_PER_BUF))
                per_buf_reg <= wd;
            if (hit(`CPWM_OFF_HALF_BUF))
                half_buf_reg <= wd;
            if (hit(`CPWM_OFF_DUTY_U))
                duty_buf_reg[0] <= wd;
            if (hit(`CPWM_OFF_DUTY_V))
                duty_buf_reg[1] <= wd;
            if (hit(`CPWM_OFF_DUTY_W))
                duty_buf_reg[2] <= wd;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // counting, boundary intervals and turning points
    assign comp       = (mode_reg >= `CPWM_MODE_PEAK);
    assign peak_sel   = (mode_reg == `CPWM_MODE_PEAK)
                     || (mode_reg == `CPWM_MODE_BOTH);
    assign trough_sel = (mode_reg == `CPWM_MODE_TROUGH)
                     || (mode_reg == `CPWM_MODE_BOTH);
    assign peak_ev    = tick && dir_up_reg && (cnt3_reg >= per_reg);
    assign trough_ev  = tick && !dir_up_reg && (cnt3_reg <= dead_reg);
    assign in_tb1     = comp && (cnt3_reg > half_reg);
    assign in_tb2     = comp && (cnt4_reg < dead_reg);

    cpwm_prescale u_prescale
    (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .run     (run_reg && comp),
        .sel     (ctrl_reg[`CPWM_CTRL_CLK]),
        .tick    (tick)
    );

    // channel three counter and count direction
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            cnt3_reg   <= '0;
            dir_up_reg <= 1'b1;
        end
        else if (hit(`CPWM_OFF_CNT3))
            cnt3_reg <= wd;
        else if (tick)
        begin
            if (peak_ev && ctrl_reg[`CPWM_CTRL_CLR] == `CPWM_CLR_PEAK)
            begin
                cnt3_reg   <= dead_reg;
                dir_up_reg <= 1'b1;
            end
            else if (peak_ev)
            begin
                cnt3_reg   <= step(cnt3_reg, 1'b0);
                dir_up_reg <= 1'b0;
            end
            else if (trough_ev)
            begin
                cnt3_reg   <= step(cnt3_reg, 1'b1);
                dir_up_reg <= 1'b1;
            end
            else
                cnt3_reg <= step(cnt3_reg, dir_up_reg);
        end
    end

    // channel four counter, held between zero and the half cycle
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            cnt4_reg <= '0;
        else if (hit(`CPWM_OFF_CNT4))
            cnt4_reg <= wd;
        else if (tick)
        begin
            if (peak_ev && ctrl_reg[`CPWM_CTRL_CLR] == `CPWM_CLR_PEAK)
                cnt4_reg <= '0;
            else if (dir_up_reg && cnt4_reg < half_reg)
                cnt4_reg <= step(cnt4_reg, 1'b1);
            else if (!dir_up_reg && cnt4_reg != '0)
                cnt4_reg <= step(cnt4_reg, 1'b0);
        end
    end

    // interval history and area b flag, set wins over clear
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            tb1_q_reg <= 1'b0;
            tb2_q_reg <= 1'b0;
            turn_reg  <= 1'b0;
        end
        else
        begin
            tb1_q_reg <= in_tb1;
            tb2_q_reg <= in_tb2;
            if (peak_ev || trough_ev)
                turn_reg <= 1'b1;
            else if (!in_tb1 && !in_tb2)
                turn_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // buffer to temporary to compare transfers
    assign move = pend_reg && !((in_tb1 && peak_sel)
                             || (in_tb2 && trough_sel));
    assign xfer = comp && ((tb1_q_reg && !in_tb1 && peak_sel)
                        || (tb2_q_reg && !in_tb2 && trough_sel));

    // phase w duty write arms the move; a new arm beats the clear
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            pend_reg <= 1'b0;
        else if (hit(`CPWM_OFF_DUTY_W))
            pend_reg <= 1'b1;
        else if (move)
            pend_reg <= 1'b0;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            tmp_per_reg  <= '0;
            tmp_half_reg <= '0;
            for (int i = 0; i < 3; i++)
                tmp_duty_reg[i] <= '0;
        end
        else if (move)
        begin
            tmp_per_reg  <= per_buf_reg;
            tmp_half_reg <= half_buf_reg;
            for (int i = 0; i < 3; i++)
                tmp_duty_reg[i] <= duty_buf_reg[i];
        end
    end

    // compare registers follow the buffers directly while stopped
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            per_reg  <= '0;
            half_reg <= '0;
            for (int i = 0; i < 3; i++)
                cmp_reg[i] <= '0;
        end
        else if (!run_reg)
        begin
            per_reg  <= per_buf_reg;
            half_reg <= half_buf_reg;
            for (int i = 0; i < 3; i++)
                cmp_reg[i] <= duty_buf_reg[i];
        end
        else if (xfer)
        begin
            per_reg  <= tmp_per_reg;
            half_reg <= tmp_half_reg;
            for (int i = 0; i < 3; i++)
                cmp_reg[i] <= tmp_duty_reg[i];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // phase compare and dead time generation
    for (genvar p = 0; p < 3; p++)
    begin : g_phase
        // area b uses the new data, otherwise the old data rules
        assign raw[p] = ((turn_reg && (in_tb1 || in_tb2))
                        ? tmp_duty_reg[p] : cmp_reg[p]) > cnt4_reg;

        cpwm_phase #(.W(CNT_W)) u_phase
        (
            .clk_sys (clk_sys),
            .rst_n   (rst_n),
            .tick    (tick),
            .en      (run_reg && comp),
            .raw     (raw[p]),
            .dead    (dead_reg),
            .pos_act (pos_act[p]),
            .neg_act (neg_act[p])
        );
    end

    // pin stage: enable gating and active level
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            pin_reg <= '0;
        else
            for (int i = 0; i < 6; i++)
                pin_reg[i] <= oe_reg[i]
                    ? (((i < 3) ? pos_act[i % 3] : neg_act[i % 3])
                       ~^ octl_reg[`CPWM_OCTL_LVL])
                    : !octl_reg[`CPWM_OCTL_LVL];
    end

    // toggle output flips at every peak and trough
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n || !octl_reg[`CPWM_OCTL_TOG] || !comp)
            tog_reg <= 1'b0;
        else if (peak_ev || trough_ev)
            tog_reg <= !tog_reg;
    end

    assign period_toggle_pin      = tog_reg;
    assign phase_u_positive_pin   = pin_reg[0];
    assign phase_u_output_pin_alt = pin_reg[0];
    assign phase_v_positive_pin   = pin_reg[1];
    assign phase_w_positive_pin   = pin_reg[2];
    assign phase_u_negative_pin   = pin_reg[3];
    assign phase_v_negative_pin   = pin_reg[4];
    assign phase_w_negative_pin   = pin_reg[5];

    ////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    chk_toggle_flip: assert property (
        (peak_ev || trough_ev) && octl_reg[`CPWM_OCTL_TOG] && comp
        |=> tog_reg != $past(tog_reg))
        else $error("toggle output missed a turning point");
    chk_peak_block: assert property (
        in_tb1 && mode_reg == `CPWM_MODE_PEAK |=> $stable(tmp_duty_reg[2]))
        else $error("move happened inside peak interval");
    chk_xfer_copy: assert property (
        xfer && run_reg |=> cmp_reg[0] == $past(tmp_duty_reg[0]))
        else $error("compare not loaded from temporary");
    chk_buf_write: assert property (
        hit(`CPWM_OFF_DUTY_U) |=> duty_buf_reg[0] == $past(wd))
        else $error("duty buffer write lost");
    chk_move_tmp: assert property (
        move |=> tmp_duty_reg[2] == $past(duty_buf_reg[2]) && !pend_reg
                 || pend_reg)
        else $error("temporary not loaded on move");
    chk_idle_mode: assert property (
        !comp ##1 !comp |-> !tog_reg && (pos_act == '0))
        else $error("outputs active outside complementary mode");
    chk_bus_answer: assert property (
        (avs_read || avs_write) && wait_reg |=> !avs_waitrequest)
        else $error("slave did not answer in one cycle");
    cov_peak: cover property (peak_ev);
    cov_xfer: cover property (xfer ##[1:100] xfer);
    cov_move_tb2: cover property (move && in_tb2);
endmodule // cpwm_top

// file: bench/cpwm_gate_stage.sv
// gate drive stage model: counts gate activity, shoot-through, toggles
`timescale 1ns/1ns
module cpwm_gate_stage
(
    input  wire logic        clk_sys,
    input  wire logic        clr,
    input  wire logic [5:0]  gate,
    input  wire logic        toggle,
    output logic [5:0][15:0] hi_cnt,
    output logic [15:0]      overlap_cnt,
    output logic [15:0]      tog_cnt
);
    logic toggle_reg;
    // per-gate active cycles, overlap cycles and toggle edges
    always_ff @(posedge clk_sys)
    begin
        toggle_reg <= toggle;
        if (clr)
        begin
            hi_cnt      <= '0;
            overlap_cnt <= 16'h0000;
            tog_cnt     <= 16'h0000;
        end
        else
        begin
            for (int i = 0; i < 6; i++)
                hi_cnt[i] <= hi_cnt[i] + 16'(gate[i]);
            if (|(gate[2:0] & gate[5:3]))
                overlap_cnt <= overlap_cnt + 16'h0001;
            if (toggle !== toggle_reg)
                tog_cnt <= tog_cnt + 16'h0001;
        end
    end
endmodule // cpwm_gate_stage

// file: bench/complementary_pwm_three_phase_tb.sv
// bench: register tasks, pin window counts, self-checking scenarios
`timescale 1ns/1ns
`include "cpwm_defines.svh"
module complementary_pwm_three_phase_tb;
    logic             clk_sys = 1'b0;
    logic             rst_n = 1'b0;
    logic [7:0]       avs_address = 8'h00;
    logic             avs_read = 1'b0;
    logic             avs_write = 1'b0;
    logic [31:0]      avs_writedata = 32'h0;
    logic [31:0]      avs_readdata;
    logic             avs_waitrequest;
    logic [31:0]      rdq;
    logic             tog;
    logic             alt;
    logic             clr = 1'b0;
    logic [5:0]       gate;
    logic [5:0][15:0] hi;
    logic [15:0]      ovl;
    logic [15:0]      tgc;
    int               fails = 0;
    int               total_checks = 0;

    cpwm_top #(.MAX_PER_CYC(255)) dut
    (
        .clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .period_toggle_pin(tog),
        .phase_u_positive_pin(gate[0]), .phase_v_positive_pin(gate[1]),
        .phase_w_positive_pin(gate[2]), .phase_u_negative_pin(gate[3]),
        .phase_v_negative_pin(gate[4]), .phase_w_negative_pin(gate[5]),
        .phase_u_output_pin_alt(alt));
    cpwm_gate_stage gs
    (
        .clk_sys(clk_sys), .clr(clr), .gate(gate), .toggle(tog),
        .hi_cnt(hi), .overlap_cnt(ovl), .tog_cnt(tgc));

    // 20 MHz clock
    always #25 clk_sys = ~clk_sys;
    ////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e)
        begin
            fails++;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
        end
    endtask
    // one avalon transfer, held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        avs_address   <= a;
        avs_write     <= w;
        avs_read      <= ~w;
        avs_writedata <= d;
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (avs_waitrequest !== 1'b0);
        rdq = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        chk(n < 50, 1);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(rdq, e);
    endtask
    // clear the stage counters, then count over 200 cycles
    task automatic win();
        repeat (4) @(posedge clk_sys);
        clr <= 1'b1;
        @(posedge clk_sys);
        clr <= 1'b0;
        repeat (200) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////
    // watchdog
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        fails++;
        final_report();
    end
    // main sequence
    initial
    begin
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        rc(`CPWM_OFF_CTRL, 32'h0);
        rc(`CPWM_OFF_MODE, 32'h0);
        rc(`CPWM_OFF_OE, 32'h0);
        rc(`CPWM_OFF_OCTL, 32'h0);
        wr(8'h40, 32'hFFFF);
        rc(8'h40, 32'h0);
        wr(`CPWM_OFF_CTRL, 32'h0);
        wr(`CPWM_OFF_DEAD, 32'h2);
        wr(`CPWM_OFF_HALF_BUF, 32'h14);
        wr(`CPWM_OFF_PER_BUF, 32'h16);
        wr(`CPWM_OFF_DUTY_U, 32'h0);
        wr(`CPWM_OFF_DUTY_V, 32'hA);
        wr(`CPWM_OFF_DUTY_W, 32'h1E);
        rc(`CPWM_OFF_PER, 32'h16);
        rc(`CPWM_OFF_HALF, 32'h14);
        wr(`CPWM_OFF_CNT3, 32'h2);
        wr(`CPWM_OFF_CNT4, 32'h0);
        wr(`CPWM_OFF_OCTL, 32'h41);
        wr(`CPWM_OFF_OE, 32'h3F);
        wr(`CPWM_OFF_MODE, {28'h0, `CPWM_MODE_PEAK});
        wr(`CPWM_OFF_START, 32'h1);
        repeat (100) @(posedge clk_sys);
        win();
        chk(hi[0], 0);
        chk(hi[3], 200);
        chk(hi[2], 200);
        chk(hi[5], 0);
        chk(ovl, 0);
        chk(hi[1] > 0 && hi[4] > 0 && hi[1] + hi[4] < 200, 1);
        chk(tgc >= 8 && tgc <= 12, 1);
        wr(`CPWM_OFF_DUTY_U, 32'hA);
        win();
        chk(hi[0], 0);
        for (int m = 13; m < 16; m++)
        begin
            wr(`CPWM_OFF_MODE, m);
            wr(`CPWM_OFF_DUTY_U, 4 * m - 44);
            wr(`CPWM_OFF_DUTY_W, 32'h1E);
            repeat (100) @(posedge clk_sys);
            win();
            chk(hi[0] > 0 && hi[0] < 200 && ovl == 0, 1);
            chk(alt, gate[0]);
        end
        // count clock divided by four: a flip every 80 cycles
        wr(`CPWM_OFF_CTRL, 32'h1);
        win();
        chk(tgc >= 2 && tgc <= 3 && ovl == 0, 1);
        wr(`CPWM_OFF_OCTL, 32'h1);
        win();
        chk(tgc, 0);
        wr(`CPWM_OFF_OE, 32'h0);
        win();
        chk(32'(|hi), 0);
        final_report();
    end
endmodule // complementary_pwm_three_phase_tb
